// ---- core/wdt_map.svh ----
// Purpose: Register map, field positions, reset values and counts
// Assumes: Word-aligned classic Wishbone slave, 8-bit byte address
// Notes:   Definitions only
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register index and byte addresses
`define WDT_CTRL_IDX   8'h21
`define WDT_CTRL_ADR   (`WDT_CTRL_IDX << 2)
`define WDT_STAT_ADR   8'h88
`define WDT_KICK_ADR   8'h8C

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define WDT_B_IRQF     7
`define WDT_B_IRQE     6
`define WDT_B_SEL3     5
`define WDT_B_UNLK     4
`define WDT_B_EN       3
// Status register field
`define WDT_B_FLAG     3

////////////////////////////////////////////////////////////////////////////////
// Reset values and counts
`define WDT_SEL_RST    4'h0
`define WDT_SEL_MAX    4'h9
`define WDT_BASE_CYC   21'h000800
`define WDT_UNLOCK_CYC 3'h4
`define WDT_RST_VEC    16'h0000

`endif

// ---- core/wdt_pkg.sv ----
// Purpose: Shared types of the watchdog
// Assumes: Nothing
// Notes:   Constants live in wdt_map.svh
package wdt_pkg;

  typedef logic [3:0] wdt_sel_t;

  typedef enum logic [2:0]
  {
    ACT_NONE = 3'h1,
    ACT_IRQ  = 3'h2,
    ACT_RST  = 3'h4
  } wdt_action_t;

endpackage

// ---- core/wdt_tick_counter.sv ----
// Purpose: Watchdog oscillator sampling and time-out counter
// Assumes: Oscillator much slower than core_clk
// Notes:   Counts rising edges of the oscillator
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"

module wdt_tick_counter
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic     core_clk,
  input  wire logic     arst_n,
  // Oscillator and control
  input  wire logic     oscIn,
  input  wire logic     clear,
  input  wire logic     run,
  input  wire wdt_sel_t sel,
  // Event
  output logic          expire
);

  logic        osc1Q;
  logic        osc2Q;
  logic        osc3Q;
  logic [19:0] cntQ;
  logic        expireQ;
  wire         tick;
  wire  [20:0] span;
  wire  [19:0] limit;
  wire         atLimit;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser, edge taken only from the second stage
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc1Q <= 1'h0;
      osc2Q <= 1'h0;
      osc3Q <= 1'h0;
    end
    else
    begin
      osc1Q <= oscIn;
      osc2Q <= osc1Q;
      osc3Q <= osc2Q;
    end
  end

  assign tick    = osc2Q & ~osc3Q;
  assign span    = `WDT_BASE_CYC << sel;
  assign limit   = 20'(span - 21'h000001);
  assign atLimit = (cntQ == limit);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cntQ    <= 20'h00000;
      expireQ <= 1'h0;
    end
    else
    begin
      expireQ <= run & ~clear & tick & atLimit;
      if (clear || !run)
        cntQ <= 20'h00000;
      else if (tick)
        cntQ <= atLimit ? 20'h00000 : cntQ + 20'h00001;
    end
  end

  assign expire = expireQ;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_count_in_range: assert property (cntQ <= limit || $changed(sel))
    else $error("counter above selected limit");

  a_clear_restarts: assert property ((clear || !run) |=> cntQ == 20'h00000)
    else $error("counter not restarted");

endmodule
`default_nettype wire

// ---- core/wdt_core_top.sv ----
// Purpose: Watchdog enable, timed disable, time-out select and action
// Assumes: Classic Wishbone master, fuse strap steady around reset
// Notes:   Time-out pulses system reset or sets the interrupt flag
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"

module wdt_core_top
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic      [31:0] wbDatO,
  output logic             wbAck,
  // Oscillator and fuse
  input  wire logic        wdogOsc,
  input  wire logic        safetyFuseProg,
  // System side
  output logic             sysResetReq,
  output logic             timeoutIrq,
  output logic      [15:0] resetVector
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic        ackQ;
  logic [31:0] datQ;
  logic        fuseTakenQ;
  logic        fuseL2Q;
  logic        enQ;
  logic        irqEnQ;
  logic        irqFlagQ;
  logic [2:0]  unlockCntQ;
  wdt_sel_t    selQ;
  logic        rstFlagQ;
  logic        sysRstQ;
  logic        irqOutQ;
  logic [15:0] vecQ;
  logic        expire;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire        reqValid = wbCyc & wbStb & ~ackQ;
  wire        wrStrobe = wbCyc & wbStb & wbWe & ackQ & wbSel[0];
  wire        hitCtrl  = (wbAdr == `WDT_CTRL_ADR);
  wire        hitStat  = (wbAdr == `WDT_STAT_ADR);
  wire        hitKick  = (wbAdr == `WDT_KICK_ADR);
  wire        ctrlWr   = wrStrobe & hitCtrl;
  wire        statWr   = wrStrobe & hitStat;
  wire        kickWr   = wrStrobe & hitKick;
  wire [7:0]  wd       = wbDatI[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Enable and unlock decisions
  wire        unlockOpen = (unlockCntQ != 3'h0);
  wire        wrUnlock   = ctrlWr & wd[`WDT_B_UNLK] & wd[`WDT_B_EN];
  wire        wrSetEn    = ctrlWr & wd[`WDT_B_EN];
  wire        wrClrEn    = ctrlWr & ~wd[`WDT_B_EN];
  // Flag forcing only matters at level one; level two is on anyway
  wire        enEff      = enQ | fuseL2Q | rstFlagQ;
  wire        clrAllowed = unlockOpen & ~fuseL2Q & ~rstFlagQ;

  // Select field is split across the control byte
  wire [3:0]  wdSel  = {wd[`WDT_B_SEL3], wd[2:0]};
  wire [3:0]  selNew = (wdSel > `WDT_SEL_MAX) ? `WDT_SEL_MAX : wdSel;
  wire        selWr  = ctrlWr & (~fuseL2Q | (unlockOpen & ~wd[`WDT_B_UNLK]));

  ////////////////////////////////////////////////////////////////////////////
  // Time-out action
  wdt_action_t act;
  assign act = irqEnQ ? ACT_IRQ : (enEff ? ACT_RST : ACT_NONE);

  wire        running = (act != ACT_NONE);
  wire        toIrq   = expire & (act == ACT_IRQ);
  wire        toRst   = expire & (act == ACT_RST);

  ////////////////////////////////////////////////////////////////////////////
  // Next values
  logic       enD;
  logic       irqEnD;
  logic       irqFlagD;
  logic       rstFlagD;
  logic [2:0] unlockCntD;

  always_comb
  begin
    enD = enQ;
    if (wrSetEn)
      enD = 1'h1;
    else if (wrClrEn && clrAllowed)
      enD = 1'h0;
  end

  always_comb
  begin
    irqEnD = irqEnQ;
    // Keeps reset protection: next time-out resets unless re-armed
    if (expire && act == ACT_IRQ && enEff)
      irqEnD = 1'h0;
    if (ctrlWr)
      irqEnD = wd[`WDT_B_IRQE];
  end

  always_comb
  begin
    irqFlagD = irqFlagQ;
    if (ctrlWr && wd[`WDT_B_IRQF])
      irqFlagD = 1'h0;
    if (toIrq)
      irqFlagD = 1'h1;
  end

  always_comb
  begin
    rstFlagD = rstFlagQ;
    if (statWr && !wd[`WDT_B_FLAG])
      rstFlagD = 1'h0;
    if (toRst)
      rstFlagD = 1'h1;
  end

  always_comb
  begin
    unlockCntD = unlockCntQ;
    if (wrUnlock)
      unlockCntD = `WDT_UNLOCK_CYC;
    else if (unlockOpen)
      unlockCntD = unlockCntQ - 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [7:0]  ctrlRd = {irqFlagQ, irqEnQ, selQ[3], unlockOpen,
                        enEff, selQ[2:0]};
  wire [7:0]  statRd = {4'h0, rstFlagQ, 3'h0};
  wire [7:0]  rdByte = hitCtrl ? ctrlRd : (hitStat ? statRd : 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: answer one cycle after the request, unmapped reads zero
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ackQ <= 1'h0;
      datQ <= 32'h00000000;
    end
    else
    begin
      ackQ <= reqValid;
      datQ <= reqValid ? {24'h000000, rdByte} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fuse strap caught once after reset release
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fuseTakenQ <= 1'h0;
      fuseL2Q    <= 1'h0;
    end
    else if (!fuseTakenQ)
    begin
      fuseTakenQ <= 1'h1;
      fuseL2Q    <= safetyFuseProg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enQ        <= 1'h0;
      irqEnQ     <= 1'h0;
      irqFlagQ   <= 1'h0;
      rstFlagQ   <= 1'h0;
      unlockCntQ <= 3'h0;
      selQ       <= `WDT_SEL_RST;
    end
    else
    begin
      enQ        <= enD;
      irqEnQ     <= irqEnD;
      irqFlagQ   <= irqFlagD;
      rstFlagQ   <= rstFlagD;
      unlockCntQ <= unlockCntD;
      if (selWr)
        selQ <= selNew;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sysRstQ <= 1'h0;
      irqOutQ <= 1'h0;
      vecQ    <= `WDT_RST_VEC;
    end
    else
    begin
      sysRstQ <= toRst;
      irqOutQ <= irqFlagD;
      vecQ    <= `WDT_RST_VEC;
    end
  end

  assign wbAck       = ackQ;
  assign wbDatO      = datQ;
  assign sysResetReq = sysRstQ;
  assign timeoutIrq  = irqOutQ;
  assign resetVector = vecQ;

  ////////////////////////////////////////////////////////////////////////////
  // Counter; a watchdog reset also restarts it like any chip reset
  wdt_tick_counter u_count
  (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .oscIn    (wdogOsc),
    .clear    (kickWr | sysRstQ),
    .run      (running),
    .sel      (selQ),
    .expire   (expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_enable_on_write: assert property (wrSetEn |=> enQ)
    else $error("enable write not taken");

  a_clear_needs_unlock: assert property ($fell(enQ) |-> $past(unlockOpen))
    else $error("enable cleared without unlock");

  a_level2_stays_on: assert property (fuseL2Q |-> enEff && !$fell(enQ))
    else $error("level two watchdog turned off");

  a_flag_forces_en: assert property (rstFlagQ |-> enEff && !$fell(enQ))
    else $error("reset flag did not hold enable");

  a_select_valid: assert property (selQ <= `WDT_SEL_MAX)
    else $error("reserved select code held");

  a_unlock_expiry: assert property (wrUnlock ##1 (!wrUnlock)[*4] |=> !unlockOpen)
    else $error("unlock window not four cycles");

  a_unlock_open: assert property (wrUnlock |=> unlockOpen[*4])
    else $error("unlock window closed early");

  a_reset_action: assert property (toRst |=> sysResetReq && rstFlagQ ##1 !sysResetReq)
    else $error("reset time-out not signalled");

  a_irq_action: assert property (toIrq |=> irqFlagQ && timeoutIrq && !sysResetReq)
    else $error("interrupt time-out not signalled");

  a_stopped_quiet: assert property (act == ACT_NONE |=> !sysResetReq)
    else $error("stopped watchdog fired");

  a_irq_rearm: assert property (toIrq && enEff && !ctrlWr |=> !irqEnQ)
    else $error("interrupt enable not dropped");

  a_ack_single: assert property (wbAck |=> !wbAck)
    else $error("ack held two cycles");

endmodule
`default_nettype wire

// ---- verif/wdt_core_top_tb.sv ----
// Purpose: Self-checking bench of the watchdog control block
// Assumes: Oscillator driven fast, toggled every 2 core cycles
// Notes:   Reads are checked from a queue of expected data
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"

module wdt_core_top_tb
  import wdt_pkg::*;
;
  localparam logic [7:0] CTL = `WDT_CTRL_ADR;
  localparam logic [7:0] STA = `WDT_STAT_ADR;
  localparam logic [7:0] KCK = `WDT_KICK_ADR;

  logic        core_clk, arst_n, wbCyc, wbStb, wbWe, wbAck;
  logic        safetyFuseProg, sysResetReq, timeoutIrq, oscRun;
  logic        wdogOsc = 1'b0;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel, c;
  logic [31:0] wbDatI, wbDatO, rng;
  logic [15:0] resetVector;
  logic [31:0] expQ[$];
  int          miscompares, num_checks, ticks, cyc, rstCnt, t0;

  wdt_core_top wdt_core_top_i (.core_clk(core_clk), .arst_n(arst_n), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAck(wbAck), .wdogOsc(wdogOsc), .safetyFuseProg(safetyFuseProg),
    .sysResetReq(sysResetReq), .timeoutIrq(timeoutIrq), .resetVector(resetVector));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic tally(input bit bad, input string m);
    num_checks++;
    if (bad)
    begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
    tally(got !== exp, $sformatf("read %h, wanted %h", got, exp));
  endtask

  task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
    tally(got !== exp, $sformatf("output %h, wanted %h", got, exp));
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Classic cycle held until ack is sampled, released at that edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                    input logic s0, input logic [31:0] e);
    rng = xs(rng);
    @(posedge core_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbDatI <= {rng[31:8], d};
    wbSel  <= {rng[3:1], s0};
    if (!we)
      expQ.push_back(e);
    // No fixed latency assumed; only the bench timeout ends a hung wait
    @(posedge core_clk);
    while (wbAck !== 1'b1)
      @(posedge core_clk);
    tally(wbAck !== 1'b1, "no bus answer");
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 1'b1, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00, 1'b1, e);
  endtask

  task automatic reset(input logic lvl2);
    @(posedge core_clk);
    arst_n         <= 1'b0;
    safetyFuseProg <= lvl2;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: oldest note against each read answer; oscillator; hang limit
  always @(posedge core_clk)
  begin
    if (wbAck === 1'b1 && wbWe === 1'b0)
      cmp_read(wbDatO, expQ.size() > 0 ? expQ.pop_front() : 32'hX);
    if (sysResetReq === 1'b1)
      rstCnt++;
    if (oscRun && cyc[0])
    begin
      wdogOsc <= ~wdogOsc;
      if (!wdogOsc)
        ticks++;
    end
    cyc++;
    if (cyc == 50000)
    begin
      miscompares++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {arst_n, wbCyc, wbStb, wbWe, safetyFuseProg, oscRun} = 6'h00;
    wbAdr  = 8'h00;
    wbSel  = 4'h0;
    wbDatI = 32'h0;
    rng    = 32'h8EC2;
    reset(1'b0);
    cmp_out(resetVector, 32'h0);
    rd(CTL, 32'h00);
    rd(STA, 32'h00);
    wr(CTL, 8'h08);
    rd(CTL, 32'h08);
    wr(CTL, 8'h00);
    rd(CTL, 32'h08);
    wb(1'b1, CTL, 8'h00, 1'b0, 32'h0);
    rd(CTL, 32'h08);
    for (int i = 0; i < 16; i++)
    begin
      c = (i > 9) ? 4'h9 : i[3:0];
      wr(CTL, {2'b00, i[3], 2'b01, i[2:0]});
      rd(CTL, {26'h0, c[3], 2'b01, c[2:0]});
    end
    wr(CTL, 8'h18);
    repeat (6) @(posedge core_clk);
    wr(CTL, 8'h00);
    rd(CTL, 32'h08);
    wr(CTL, 8'h18);
    wr(CTL, 8'h00);
    rd(CTL, 32'h00);
    // Reset action, kicked part way so the restart shows in the count
    wr(CTL, 8'h08);
    t0 = ticks;
    oscRun <= 1'b1;
    while (ticks - t0 < 1000)
      @(posedge core_clk);
    wr(KCK, 8'h00);
    t0 = ticks;
    repeat (9000)
    begin
      @(posedge core_clk);
      if (sysResetReq === 1'b1)
        break;
    end
    oscRun <= 1'b0;
    cmp_out(ticks - t0 >= 2047 && ticks - t0 <= 2050, 1);
    @(posedge core_clk);
    cmp_out(sysResetReq, 0);
    rd(STA, 32'h08);
    rd(CTL, 32'h08);
    wr(CTL, 8'h18);
    wr(CTL, 8'h00);
    rd(CTL, 32'h08);
    wr(STA, 8'h08);
    rd(STA, 32'h08);
    wr(STA, 8'h00);
    wr(CTL, 8'h18);
    wr(CTL, 8'h00);
    rd(CTL, 32'h00);
    // Interrupt action with the enable bit off
    wr(CTL, 8'h40);
    t0 = ticks;
    oscRun <= 1'b1;
    repeat (9000)
    begin
      @(posedge core_clk);
      if (timeoutIrq === 1'b1)
        break;
    end
    oscRun <= 1'b0;
    cmp_out(ticks - t0 >= 2047 && ticks - t0 <= 2051, 1);
    rd(CTL, 32'hC0);
    wr(CTL, 8'h80);
    rd(CTL, 32'h00);
    cmp_out(timeoutIrq, 0);
    // Both off: timer must stay stopped
    t0 = ticks;
    oscRun <= 1'b1;
    while (ticks - t0 < 2300)
      @(posedge core_clk);
    oscRun <= 1'b0;
    cmp_out(rstCnt, 1);
    cmp_out(timeoutIrq, 0);
    // Safety level two
    reset(1'b1);
    rd(CTL, 32'h08);
    wr(CTL, 8'h18);
    wr(CTL, 8'h00);
    rd(CTL, 32'h08);
    wr(CTL, 8'h18);
    wr(CTL, 8'h01);
    rd(CTL, 32'h09);
    wr(CTL, 8'h0A);
    rd(CTL, 32'h09);
    cmp_out(resetVector, 32'h0);
    final_report();
  end

endmodule
`default_nettype wire
